// >>> adts_top.sv
// APB register block for converter timing and channel-0 input selection
`timescale 1ns/1ps
`include "adts_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// (R1) Source bit set picks internal RC clock; clear divides instruction clock.
// (R2) Timing bits 14:13 read zero and ignore writes.
// (R3) Five-bit auto-sample field 12:8 gives sampling of N conversion periods.
// (R4) Software should avoid an auto-sample time of zero.
// (R5) Divider code N gives a conversion period of N+1 instruction cycles.
// (R6) Largest divider code 0x3f gives 64 cycles; higher codes reserved.
// (R7) Input select holds settings A low, B high: 4-bit positive, negative bit.
// (R8) Software avoids positive codes 1101, 1110 and absent inputs 6-8.
module adts_top (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   output logic                   conv_clock_source_sel,
   output logic [4:0]             auto_sample_periods,
   output logic [7:0]             conv_clock_divider,
   output adts_pkg::adts_mux_t    mux_sel,
   output logic                   conv_tick,
   output logic                   sampling,
   output logic                   sample_done
);
   import adts_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   logic [15:0]  timing_q, timing_d;
   logic [15:0]  insel_q, insel_d;
   logic [31:0]  rdata_q, rdata_d;
   logic         ready_q, ready_d;
   logic         err_q, err_d;
   logic         wr_en;
   logic         start_req;
   adts_state_t  state_q, state_d;
   logic [4:0]   scnt_q, scnt_d;
   logic         sample_done_q, sample_done_d;
   logic         samp_q, samp_d;
   logic         tick_q;
   adts_tick_if  tif ();

   assign wr_en = psel && !penable && pwrite;

   // Writes land in the setup cycle; the access phase then completes in one cycle
   always_comb begin
      timing_d  = timing_q;
      insel_d   = insel_q;
      rdata_d   = rdata_q;
      ready_d   = 1'b0;
      err_d     = 1'b0;
      start_req = 1'b0;
      if (psel && !penable) begin
         ready_d = 1'b1;
         case (paddr)
            `ADTS_OFF_TIMING: begin
               if (pwrite) begin
                  timing_d = pwdata[15:0] & `ADTS_TIMING_WMASK; // (R2) (R3) (R5)
               end
               rdata_d = {16'h0000, timing_q};
            end
            `ADTS_OFF_INSEL: begin
               if (pwrite) begin
                  insel_d = pwdata[15:0] & `ADTS_INSEL_WMASK; // (R7)
               end
               rdata_d = {16'h0000, insel_q};
            end
            `ADTS_OFF_STATUS: begin
               rdata_d = {30'h0, sample_done_q, (state_q == ADTS_SAMPLE)};
            end
            `ADTS_OFF_START: begin
               start_req = wr_en && pwdata[0];
               rdata_d   = 32'h0;
            end
            default: begin
               err_d   = 1'b1;
               rdata_d = 32'h0;
            end
         endcase
         if (pwrite) begin
            rdata_d = 32'h0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Auto-sample timer counting conversion clock periods
   always_comb begin
      state_d       = state_q;
      scnt_d        = scnt_q;
      sample_done_d = sample_done_q;
      case (state_q)
         ADTS_IDLE: begin
            if (start_req) begin
               sample_done_d = 1'b0;
               scnt_d        = timing_q[`ADTS_SAMC_MSB:`ADTS_SAMC_LSB];
               // Zero periods ends at once; allowed though software should avoid it
               state_d = (timing_q[`ADTS_SAMC_MSB:`ADTS_SAMC_LSB] == 5'h00) ?
                         ADTS_DONE : ADTS_SAMPLE; // (R3) (R4)
            end
         end
         ADTS_SAMPLE: begin
            if (tif.tick) begin
               if (scnt_q <= 5'h01) begin // (R3)
                  state_d = ADTS_DONE;
               end
               scnt_d = scnt_q - 5'h01;
            end
         end
         ADTS_DONE: begin
            sample_done_d = 1'b1;
            state_d       = ADTS_IDLE;
         end
         default: begin
            state_d = ADTS_IDLE;
         end
      endcase
      samp_d = (state_d == ADTS_SAMPLE);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_q      <= `ADTS_TIMING_RST;
         insel_q       <= `ADTS_INSEL_RST;
         rdata_q       <= 32'h0;
         ready_q       <= 1'b0;
         err_q         <= 1'b0;
         state_q       <= ADTS_IDLE;
         scnt_q        <= 5'h00;
         sample_done_q <= 1'b0;
         samp_q        <= 1'b0;
         tick_q        <= 1'b0;
      end else begin
         timing_q      <= timing_d;
         insel_q       <= insel_d;
         rdata_q       <= rdata_d;
         ready_q       <= ready_d;
         err_q         <= err_d;
         state_q       <= state_d;
         scnt_q        <= scnt_d;
         sample_done_q <= sample_done_d;
         samp_q        <= samp_d;
         tick_q        <= tif.tick;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   assign tif.src_rc = timing_q[`ADTS_SRC_BIT]; // (R1)
   assign tif.div    = timing_q[`ADTS_DIV_MSB:0];

   adts_tick_gen u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif)
   );

   assign pready                = ready_q;
   assign prdata                = rdata_q;
   assign pslverr               = err_q;
   assign conv_clock_source_sel = timing_q[`ADTS_SRC_BIT];
   assign auto_sample_periods   = timing_q[`ADTS_SAMC_MSB:`ADTS_SAMC_LSB];
   assign conv_clock_divider    = timing_q[`ADTS_DIV_MSB:0];
   assign mux_sel               = {insel_q[15], insel_q[11:8], insel_q[7], insel_q[3:0]}; // (R7)
   assign conv_tick             = tick_q;
   assign sampling              = samp_q;
   assign sample_done           = sample_done_q;
endmodule // adts_top

// >>> adts_consts.svh
// Offsets, field positions, reset values and timing counts of the converter timing block
`ifndef ADTS_CONSTS_SVH
`define ADTS_CONSTS_SVH
`define ADTS_OFF_TIMING      12'h000
`define ADTS_OFF_INSEL       12'h004
`define ADTS_OFF_STATUS      12'h008
`define ADTS_OFF_START       12'h00c
`define ADTS_TIMING_RST      16'h0000
`define ADTS_INSEL_RST       16'h0000
`define ADTS_TIMING_WMASK    16'h9fff
`define ADTS_INSEL_WMASK     16'h8f8f
`define ADTS_SRC_BIT         15
`define ADTS_SAMC_LSB        8
`define ADTS_SAMC_MSB        12
`define ADTS_DIV_MSB         7
`define ADTS_DIV_MAX         8'h3f
`define ADTS_RC_HALF_NS      250
`define ADTS_CLK_NS          8
`define ADTS_RC_HALF_CYC     (((`ADTS_RC_HALF_NS) + (`ADTS_CLK_NS) - 1) / (`ADTS_CLK_NS))
`endif

// >>> adts_pkg.sv
// Types shared by the converter timing block
package adts_pkg;
   typedef enum logic [1:0] {ADTS_IDLE, ADTS_SAMPLE, ADTS_DONE} adts_state_t;
   typedef struct packed {
      logic       neg_b;
      logic [3:0] pos_b;
      logic       neg_a;
      logic [3:0] pos_a;
   } adts_mux_t;
endpackage

// >>> adts_tick_if.sv
// Conversion clock tick carrier between divider and sampler
`timescale 1ns/1ps
interface adts_tick_if;
   logic       src_rc;
   logic [7:0] div;
   logic       tick;
   modport gen (input src_rc, input div, output tick);
   modport use_ (output src_rc, output div, input tick);
endinterface

// >>> adts_tick_gen.sv
// Conversion clock period generator: divider from pclk or internal RC stand-in
`timescale 1ns/1ps
`include "adts_consts.svh"
module adts_tick_gen (
   input  wire logic pclk,
   input  wire logic presetn,
   adts_tick_if.gen  tif
);
   import adts_pkg::*;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] rcc_q, rcc_d;
   logic       rc_q, rc_d;
   logic       tick_q, tick_d;
   logic [7:0] lim;

   always_comb begin
      // Reserved codes clamp so the period never exceeds 64 cycles
      lim    = (tif.div > `ADTS_DIV_MAX) ? `ADTS_DIV_MAX : tif.div; // (R6)
      cnt_d  = cnt_q;
      rcc_d  = rcc_q;
      rc_d   = rc_q;
      tick_d = 1'b0;
      // Free-running stand-in for the dedicated RC oscillator
      if (rcc_q >= 8'(`ADTS_RC_HALF_CYC - 1)) begin
         rcc_d = 8'h00;
         rc_d  = ~rc_q;
      end else begin
         rcc_d = rcc_q + 8'h01;
      end
      if (tif.src_rc) begin // (R1)
         tick_d = (rcc_q >= 8'(`ADTS_RC_HALF_CYC - 1)) && rc_q;
         cnt_d  = 8'h00;
      end else if (cnt_q >= lim) begin // (R5)
         cnt_d  = 8'h00;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 8'h00;
         rcc_q  <= 8'h00;
         rc_q   <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         rcc_q  <= rcc_d;
         rc_q   <= rc_d;
         tick_q <= tick_d;
      end
   end
   assign tif.tick = tick_q;
endmodule // adts_tick_gen

// >>> adts_top_sva.sv
// Assertion checker for the converter timing register block
`timescale 1ns/1ps
`include "adts_consts.svh"
module adts_sva (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   input wire logic                conv_clock_source_sel,
   input wire logic [4:0]          auto_sample_periods,
   input wire logic [7:0]          conv_clock_divider,
   input wire adts_pkg::adts_mux_t mux_sel,
   input wire logic                conv_tick
);
   import adts_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wt;
   logic wi;
   assign wt = psel && !penable && pwrite && paddr == `ADTS_OFF_TIMING;
   assign wi = psel && !penable && pwrite && paddr == `ADTS_OFF_INSEL;
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_src; wt |=> conv_clock_source_sel == $past(pwdata[15]); endproperty
   a_src: assert property (p_src) else $error("source bit not stored");
   property p_samc; wt |=> auto_sample_periods == $past(pwdata[12:8]); endproperty
   a_samc: assert property (p_samc) else $error("sample field not stored");
   property p_div; wt |=> conv_clock_divider == $past(pwdata[7:0]); endproperty
   a_div: assert property (p_div) else $error("divider not stored");
   property p_gap; pready && paddr == `ADTS_OFF_TIMING |-> prdata[14:13] == 2'h0; endproperty
   a_gap: assert property (p_gap) else $error("unused bits read set");
   property p_mux; wi |=> mux_sel == {$past(pwdata[15]), $past(pwdata[11:7]), $past(pwdata[3:0])};
   endproperty
   a_mux: assert property (p_mux) else $error("input select not stored");
   // Slowest legal code and clamped codes both space ticks far apart
   property p_slow; conv_tick && !conv_clock_source_sel && conv_clock_divider >= 8'h3f
      |=> !conv_tick [*8]; endproperty
   a_slow: assert property (p_slow) else $error("tick too soon");
   property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("error read not zero");
endmodule // adts_sva
bind adts_top adts_sva u_adts_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .prdata, .pslverr, .conv_clock_source_sel, .auto_sample_periods,
   .conv_clock_divider, .mux_sel, .conv_tick);

// >>> testbench.sv
// Self-checking bench for the converter timing register block
`timescale 1ns/1ps
`include "adts_consts.svh"
module testbench;
   import adts_pkg::*;
   typedef struct packed {logic [11:0] a; logic [15:0] w; logic [15:0] r;} adts_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, src, tick, smp, sd, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  samc;
   logic [7:0]  div;
   adts_mux_t   mux;
   int          failures = 0, n_checks = 0, g;
   adts_row_t   rows [5] = '{'{12'h000, 16'hffff, 16'h9fff}, '{12'h000, 16'h1f3f, 16'h1f3f},
      '{12'h000, 16'h0001, 16'h0001}, '{12'h004, 16'hffff, 16'h8f8f},
      '{12'h004, 16'h0f80, 16'h0f80}};
   adts_top u_adts_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .conv_clock_source_sel(src), .auto_sample_periods(samc),
      .conv_clock_divider(div), .mux_sel(mux), .conv_tick(tick), .sampling(smp),
      .sample_done(sd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      er = pslverr;
      check(pready, 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Spacing between two ticks, after any leftover tick of the old setting
   task automatic gap(input logic [31:0] exp);
      int c;
      c = 0;
      do @(posedge pclk); while (tick !== 1'h1);
      do begin
         @(posedge pclk);
         c++;
      end while (tick !== 1'h1 && c < 200);
      check(c, exp);
   endtask
   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      summarize;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `ADTS_OFF_INSEL, 32'h0);
      check(rd, 32'h0);
      foreach (rows[i]) begin
         apb(1'h1, rows[i].a, {16'h0, rows[i].w});
         check(rows[i].a == 12'h0 ? {src, 2'h0, samc, div} : {mux[9], 3'h0, mux[8:4], 3'h0,
            mux[3:0]}, rows[i].r);
         apb(1'h0, rows[i].a, 32'h0);
         check(rd, {16'h0, rows[i].r});
      end
      apb(1'h0, 12'h010, 32'h0);
      check({er, rd[30:0]}, 32'h80000000);
      $display("register tests done");
      gap(2);
      apb(1'h1, `ADTS_OFF_TIMING, 32'h3f);
      gap(64);
      apb(1'h1, `ADTS_OFF_TIMING, 32'hff);
      gap(64);
      apb(1'h1, `ADTS_OFF_TIMING, 32'h8000);
      gap(64);
      apb(1'h1, `ADTS_OFF_TIMING, 32'h0300);
      apb(1'h1, `ADTS_OFF_START, 32'h1);
      g = 0;
      while (smp !== 1'h1 && g < 10) begin
         @(posedge pclk);
         g++;
      end
      g = 0;
      while (smp === 1'h1 && g < 100) begin
         @(posedge pclk);
         g++;
      end
      check(g, 3);
      apb(1'h0, `ADTS_OFF_STATUS, 32'h0);
      check(rd, 32'h2);
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `ADTS_OFF_TIMING, 32'h0);
      check(rd, 32'h0);
      // Zero sample periods: legal but discouraged, ends without sampling
      apb(1'h1, `ADTS_OFF_START, 32'h1);
      check(smp, 1'h0);
      apb(1'h0, `ADTS_OFF_STATUS, 32'h0);
      check(rd, 32'h2);
      $display("timing tests done");
      summarize;
   end
endmodule // testbench
